// ===== hw/kfs_baud_map.sv
`timescale 1ns/100ps
module kfs_baud_map (
	// code in
	input wire logic [3:0] code_in,
	// rate out
	output logic [10:0] kbit_out,
	output logic valid_out
);
	always_comb begin
		valid_out = 1'b1;
		unique case (code_in)
			4'h0: kbit_out = 11'd10;
			4'h1: kbit_out = 11'd20;
			4'h2: kbit_out = 11'd50;
			4'h3: kbit_out = 11'd100;
			4'h4: kbit_out = 11'd125;
			4'h5: kbit_out = 11'd250;
			4'h6: kbit_out = 11'd333;
			4'h7: kbit_out = 11'd500;
			4'h8: kbit_out = 11'd666;
			4'h9: kbit_out = 11'd800;
			4'ha: kbit_out = 11'd1000;
			default: begin
				kbit_out = 11'd0;
				valid_out = 1'b0;
			end
		endcase
	end
endmodule

// ===== hw/kfs_pkg.sv
package kfs_pkg;
	// fault numbers shown on the display
	localparam logic [5:0] FC_UNDERVOLTAGE = 6'h05;
	localparam logic [5:0] FC_PHASE_LOSS = 6'h13;
	localparam logic [5:0] FC_CAN_BUS_OFF = 6'h17;
	localparam logic [5:0] FC_WARNING_AS_FAULT = 6'h18;
	localparam logic [5:0] FC_RESTART_LOCK_CONFLICT = 6'h1b;
	localparam logic [5:0] FC_NONE = 6'h00;
	// bit positions in the pending fault vector
	localparam int FB_UNDERVOLTAGE = 0;
	localparam int FB_PHASE_LOSS = 1;
	localparam int FB_CAN_BUS_OFF = 2;
	localparam int FB_WARNING_AS_FAULT = 3;
	localparam int FB_RESTART_LOCK_CONFLICT = 4;
	localparam int FAULT_NUM = 5;
	// clearable without full restart
	localparam logic [4:0] FAULT_CLEARABLE = 5'h03;
	// key timing, edit steps, reset values and limits
	localparam int DOUBLE_GAP_TICKS = 4000;
	localparam logic [15:0] DEFAULT_GAP = 16'h0fa0;
	localparam logic [15:0] EDIT_STEP_ONE = 16'h0001;
	localparam logic [15:0] EDIT_STEP_TEN = 16'h000a;
	localparam logic [15:0] EDIT_RESET = 16'h0000;
	localparam logic [3:0] MENU_RESET = 4'h0;
	localparam logic [3:0] BAUD_CODE_MAX = 4'ha;
	localparam logic [2:0] OPMODE_SERVICE = 3'h0;
	localparam logic [2:0] MAX_STATIONS = 3'h6;

	typedef struct packed {
		logic undervoltage;
		logic phase_loss;
		logic can_bus_off;
		logic warning_as_fault;
		logic restart_lock_enable;
		logic drive_enable;
	} kfs_fault_in_t;

	typedef struct packed {
		logic service_start;
		logic service_stop;
		logic host_disable;
		logic clear_fault_command;
	} kfs_host_cmd_t;

	typedef enum logic [3:0] {
		KEY_IDLE = 4'b0001,
		KEY_WAIT = 4'b0010,
		KEY_CHORD = 4'b0100,
		KEY_RELEASE = 4'b1000
	} kfs_key_state_t;
endpackage

// ===== hw/kfs_supervisor.sv
`timescale 1ns/100ps
// Summary of operation
// - single up press moves menu up or adds one to edited number
// - single down press moves menu down or subtracts one
// - two quick presses of one key change number by ten
// - left pressed while right held accepts number and returns a level
// - only the standard menu is offered by default
// - extended menu only if right key held at supply power-up
// - node address and baud apply only after a supply power cycle
// - baud code 0..10 maps to 10..1000 kbit/s
// - each fault shows as a coded fault number
// - any fault opens ready contact and disables output stage
// - any fault engages holding brake when installed
// - clear-fault command cancels clearable faults without reset
// - reset with only clearable faults pending only clears faults
// - undervoltage raises fault 5
// - CAN bus-off raises fault 23
// - warning configured as fault raises fault 24
// - restart-lock enable together with drive enable raises fault 27
// - phase-loss fault can be suppressed by configuration
// - service start sets opmode 0 and enables output stage
// - service runs until stop or a pending fault; host disable turns output stage off
// - respond on multilink only when station address matches
// - warnings show as codes without tripping ready or output stage
module kfs_supervisor #(
	parameter logic [15:0] GAP_TICKS = kfs_pkg::DEFAULT_GAP
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic resetn_in,
	// keys, sampled on key tick
	input wire logic key_tick_in,
	input wire logic key_up_in,
	input wire logic key_down_in,
	input wire logic key_left_in,
	input wire logic key_right_in,
	input wire logic edit_mode_in,
	// node settings entered on panel
	input wire logic [6:0] node_addr_set_in,
	input wire logic [3:0] baud_code_set_in,
	// fault sources and config
	input wire kfs_pkg::kfs_fault_in_t fault_src_in,
	input wire logic phase_loss_as_warning_in,
	input wire logic brake_installed_in,
	input wire logic warning_active_in,
	input wire logic [5:0] warning_code_in,
	// reset request from panel or reset input
	input wire logic reset_request_in,
	// host
	input wire logic host_valid_in,
	input wire logic [2:0] host_station_in,
	input wire logic [2:0] station_addr_in,
	input wire kfs_pkg::kfs_host_cmd_t host_cmd_in,
	// panel outputs
	output logic [3:0] menu_index_out,
	output logic [15:0] edit_value_out,
	output logic accept_return_out,
	output logic extended_menu_out,
	// applied node settings
	output logic [6:0] node_addr_out,
	output logic [10:0] baud_kbit_out,
	// display
	output logic [5:0] display_fault_out,
	output logic [5:0] display_warning_out,
	// power side
	output logic ready_to_operate_contact_out,
	output logic output_stage_enable_out,
	output logic brake_engage_out,
	output logic [2:0] opmode_out,
	output logic service_active_out,
	output logic full_restart_out,
	output logic host_ack_out
);
	logic rst_s1_r, rst_s2_r;
	logic rstn;
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rst_s1_r <= 1'b0;
			rst_s2_r <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_s2_r <= rst_s1_r;
		end
	end
	assign rstn = rst_s2_r;

	// power-up capture: one shot after reset release
	logic captured_r, captured_nxt;
	logic extended_r, extended_nxt;
	logic [6:0] node_r, node_nxt;
	logic [3:0] baud_r, baud_nxt;
	logic [10:0] kbit_w;
	logic [10:0] kbit_r;
	logic baud_ok_w;

	kfs_baud_map u_baud (
		.code_in(baud_r),
		.kbit_out(kbit_w),
		.valid_out(baud_ok_w)
	);

	always_comb begin
		captured_nxt = 1'b1;
		extended_nxt = extended_r;
		node_nxt = node_r;
		baud_nxt = baud_r;
		if (!captured_r) begin
			extended_nxt = key_right_in;
			node_nxt = node_addr_set_in;
			baud_nxt = (baud_code_set_in > kfs_pkg::BAUD_CODE_MAX) ? 4'h0 : baud_code_set_in;
		end
	end

	always_ff @(posedge clk_in or negedge rstn) begin
		if (!rstn) begin
			captured_r <= 1'b0;
			extended_r <= 1'b0;
			node_r <= 7'h00;
			baud_r <= 4'h0;
			kbit_r <= 11'h000;
		end else begin
			captured_r <= captured_nxt;
			extended_r <= extended_nxt;
			node_r <= node_nxt;
			baud_r <= baud_nxt;
			kbit_r <= baud_ok_w ? kbit_w : 11'h000;
		end
	end

	// key handling
	kfs_pkg::kfs_key_state_t key_st_r, key_st_nxt;
	logic [15:0] gap_r, gap_nxt;
	logic last_up_r, last_up_nxt;
	logic [3:0] menu_r, menu_nxt;
	logic [15:0] edit_r, edit_nxt;
	logic acc_r, acc_nxt;
	logic up_q_r, dn_q_r, lf_q_r;
	logic up_edge, dn_edge, lf_edge;

	assign up_edge = key_tick_in && key_up_in && !up_q_r && !key_right_in;
	assign dn_edge = key_tick_in && key_down_in && !dn_q_r && !key_right_in;
	assign lf_edge = key_tick_in && key_left_in && !lf_q_r;

	function automatic logic [15:0] step_edit(input logic [15:0] v, input logic up, input logic [15:0] s);
		step_edit = up ? v + s : v - s;
	endfunction

	always_comb begin
		key_st_nxt = key_st_r;
		gap_nxt = gap_r;
		last_up_nxt = last_up_r;
		menu_nxt = menu_r;
		edit_nxt = edit_r;
		acc_nxt = 1'b0;
		if (key_tick_in && gap_r != 16'h0000) begin
			gap_nxt = gap_r - 16'h0001;
		end
		unique case (key_st_r)
			kfs_pkg::KEY_IDLE: begin
				if (key_tick_in && key_right_in) begin
					key_st_nxt = kfs_pkg::KEY_CHORD;
				end else if (up_edge || dn_edge) begin
					last_up_nxt = up_edge;
					gap_nxt = GAP_TICKS;
					key_st_nxt = kfs_pkg::KEY_WAIT;
					if (edit_mode_in) begin
						edit_nxt = step_edit(edit_r, up_edge, kfs_pkg::EDIT_STEP_ONE);
					end else begin
						menu_nxt = up_edge ? menu_r + 4'h1 : menu_r - 4'h1;
					end
				end
			end
			kfs_pkg::KEY_WAIT: begin
				if (key_tick_in && key_right_in) begin
					key_st_nxt = kfs_pkg::KEY_CHORD;
				end else if (gap_r != 16'h0000 && ((up_edge && last_up_r) || (dn_edge && !last_up_r))) begin
					// gap still running: the same key again counts as the second press of a double press
					// first press already stepped one, so step nine more in the same direction for ten total
					key_st_nxt = kfs_pkg::KEY_IDLE;
					if (edit_mode_in) begin
						edit_nxt = step_edit(edit_r, last_up_r,
							kfs_pkg::EDIT_STEP_TEN - kfs_pkg::EDIT_STEP_ONE);
					end
				end else if (up_edge || dn_edge) begin
					last_up_nxt = up_edge;
					gap_nxt = GAP_TICKS;
					if (edit_mode_in) begin
						edit_nxt = step_edit(edit_r, up_edge, kfs_pkg::EDIT_STEP_ONE);
					end else begin
						menu_nxt = up_edge ? menu_r + 4'h1 : menu_r - 4'h1;
					end
				end else if (key_tick_in && gap_r == 16'h0000) begin
					key_st_nxt = kfs_pkg::KEY_IDLE;
				end
			end
			kfs_pkg::KEY_CHORD: begin
				if (key_tick_in && !key_right_in) begin
					key_st_nxt = kfs_pkg::KEY_IDLE;
				end else if (lf_edge) begin
					acc_nxt = 1'b1;
					menu_nxt = kfs_pkg::MENU_RESET;
					key_st_nxt = kfs_pkg::KEY_RELEASE;
				end
			end
			kfs_pkg::KEY_RELEASE: begin
				if (key_tick_in && !key_right_in && !key_left_in) begin
					key_st_nxt = kfs_pkg::KEY_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk_in or negedge rstn) begin
		if (!rstn) begin
			key_st_r <= kfs_pkg::KEY_IDLE;
			gap_r <= 16'h0000;
			last_up_r <= 1'b0;
			menu_r <= kfs_pkg::MENU_RESET;
			edit_r <= kfs_pkg::EDIT_RESET;
			acc_r <= 1'b0;
			up_q_r <= 1'b0;
			dn_q_r <= 1'b0;
			lf_q_r <= 1'b0;
		end else begin
			key_st_r <= key_st_nxt;
			gap_r <= gap_nxt;
			last_up_r <= last_up_nxt;
			menu_r <= menu_nxt;
			edit_r <= edit_nxt;
			acc_r <= acc_nxt;
			if (key_tick_in) begin
				up_q_r <= key_up_in;
				dn_q_r <= key_down_in;
				lf_q_r <= key_left_in;
			end
		end
	end

	// faults and service function
	logic [4:0] pend_r, pend_nxt;
	logic [4:0] raw;
	logic svc_r, svc_nxt;
	logic stage_r, stage_nxt;
	logic [2:0] opm_r, opm_nxt;
	logic restart_r, restart_nxt;
	logic ack_r, ack_nxt;
	logic [5:0] dfault_r, dfault_nxt;
	logic [5:0] dwarn_r, dwarn_nxt;
	logic selected;
	logic clear_req;

	always_comb begin
		raw = 5'h00;
		raw[kfs_pkg::FB_UNDERVOLTAGE] = fault_src_in.undervoltage;
		raw[kfs_pkg::FB_PHASE_LOSS] = fault_src_in.phase_loss && !phase_loss_as_warning_in;
		raw[kfs_pkg::FB_CAN_BUS_OFF] = fault_src_in.can_bus_off;
		raw[kfs_pkg::FB_WARNING_AS_FAULT] = fault_src_in.warning_as_fault;
		raw[kfs_pkg::FB_RESTART_LOCK_CONFLICT] =
			fault_src_in.restart_lock_enable && fault_src_in.drive_enable;
	end

	assign selected = host_valid_in && host_station_in == station_addr_in
		&& station_addr_in < kfs_pkg::MAX_STATIONS;
	assign clear_req = (selected && host_cmd_in.clear_fault_command)
		|| (reset_request_in && (pend_r & ~kfs_pkg::FAULT_CLEARABLE) == 5'h00);

	always_comb begin
		pend_nxt = pend_r;
		if (clear_req) begin
			pend_nxt = pend_r & ~kfs_pkg::FAULT_CLEARABLE;
		end
		pend_nxt = pend_nxt | raw; // set wins over clear
		restart_nxt = reset_request_in && (pend_r & ~kfs_pkg::FAULT_CLEARABLE) != 5'h00;
		svc_nxt = svc_r;
		stage_nxt = stage_r;
		opm_nxt = opm_r;
		ack_nxt = selected;
		if (selected && host_cmd_in.service_start) begin
			svc_nxt = 1'b1;
			opm_nxt = kfs_pkg::OPMODE_SERVICE;
			stage_nxt = 1'b1;
		end
		if (selected && host_cmd_in.service_stop) begin
			svc_nxt = 1'b0;
		end
		if (selected && host_cmd_in.host_disable) begin
			stage_nxt = 1'b0;
		end
		if (pend_nxt != 5'h00) begin
			stage_nxt = 1'b0;
			svc_nxt = 1'b0;
		end
		if (pend_nxt[kfs_pkg::FB_UNDERVOLTAGE]) begin
			dfault_nxt = kfs_pkg::FC_UNDERVOLTAGE;
		end else if (pend_nxt[kfs_pkg::FB_PHASE_LOSS]) begin
			dfault_nxt = kfs_pkg::FC_PHASE_LOSS;
		end else if (pend_nxt[kfs_pkg::FB_CAN_BUS_OFF]) begin
			dfault_nxt = kfs_pkg::FC_CAN_BUS_OFF;
		end else if (pend_nxt[kfs_pkg::FB_WARNING_AS_FAULT]) begin
			dfault_nxt = kfs_pkg::FC_WARNING_AS_FAULT;
		end else if (pend_nxt[kfs_pkg::FB_RESTART_LOCK_CONFLICT]) begin
			dfault_nxt = kfs_pkg::FC_RESTART_LOCK_CONFLICT;
		end else begin
			dfault_nxt = kfs_pkg::FC_NONE;
		end
		dwarn_nxt = warning_active_in ? warning_code_in : kfs_pkg::FC_NONE;
	end

	always_ff @(posedge clk_in or negedge rstn) begin
		if (!rstn) begin
			pend_r <= 5'h00;
			svc_r <= 1'b0;
			stage_r <= 1'b0;
			opm_r <= kfs_pkg::OPMODE_SERVICE;
			restart_r <= 1'b0;
			ack_r <= 1'b0;
			dfault_r <= kfs_pkg::FC_NONE;
			dwarn_r <= kfs_pkg::FC_NONE;
		end else begin
			pend_r <= pend_nxt;
			svc_r <= svc_nxt;
			stage_r <= stage_nxt;
			opm_r <= opm_nxt;
			restart_r <= restart_nxt;
			ack_r <= ack_nxt;
			dfault_r <= dfault_nxt;
			dwarn_r <= dwarn_nxt;
		end
	end

	logic ready_r, brake_r;
	always_ff @(posedge clk_in or negedge rstn) begin
		if (!rstn) begin
			ready_r <= 1'b0;
			brake_r <= 1'b0;
		end else begin
			ready_r <= (pend_nxt == 5'h00);
			brake_r <= (pend_nxt != 5'h00) && brake_installed_in;
		end
	end

	assign menu_index_out = menu_r;
	assign edit_value_out = edit_r;
	assign accept_return_out = acc_r;
	assign extended_menu_out = extended_r;
	assign node_addr_out = node_r;
	assign baud_kbit_out = kbit_r;
	assign display_fault_out = dfault_r;
	assign display_warning_out = dwarn_r;
	assign ready_to_operate_contact_out = ready_r;
	assign output_stage_enable_out = stage_r;
	assign brake_engage_out = brake_r;
	assign opmode_out = opm_r;
	assign service_active_out = svc_r;
	assign full_restart_out = restart_r;
	assign host_ack_out = ack_r;
endmodule

// ===== sim/kfs_panel_model.sv
`timescale 1ns/100ps
module kfs_panel_model (
	// clock
	input wire logic clk_in,
	// keys {up, down, left, right}
	output logic key_tick_out,
	output logic [3:0] keys_out,
	// serial host
	output logic host_valid_out,
	output logic [2:0] host_station_out,
	output kfs_pkg::kfs_host_cmd_t host_cmd_out
);
	initial begin
		key_tick_out = 1'b0;
		keys_out = 4'h0;
		host_valid_out = 1'b0;
		host_station_out = 3'h0;
		host_cmd_out = 4'h0;
	end
	// tick every other cycle so a two-cycle key level always spans one tick
	always @(negedge clk_in) key_tick_out <= ~key_tick_out;
	task automatic hold(input logic [3:0] k);
		keys_out = k;
	endtask
	task automatic press(input logic [3:0] k, input logic [3:0] keep, input int n);
		keys_out = k;
		repeat (2) @(negedge clk_in);
		keys_out = keep;
		repeat (2 * n) @(negedge clk_in);
	endtask
	// lines carry junk once valid drops; one idle cycle always parts two commands
	task automatic send(input logic [2:0] st, input logic [3:0] c);
		@(negedge clk_in);
		host_valid_out = 1'b1;
		host_station_out = st;
		host_cmd_out = c;
		@(negedge clk_in);
		host_valid_out = 1'b0;
		host_station_out = ~st;
		host_cmd_out = ~c;
	endtask
endmodule

// ===== sim/kfs_supervisor_asserts.sv
`timescale 1ns/100ps
module kfs_supervisor_asserts (
	// clock, reset and stimulus
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire kfs_pkg::kfs_fault_in_t fault_src_in,
	input wire logic brake_installed_in,
	input wire logic warning_active_in,
	input wire logic host_valid_in,
	input wire logic [2:0] host_station_in,
	input wire logic [2:0] station_addr_in,
	input wire kfs_pkg::kfs_host_cmd_t host_cmd_in,
	// watched outputs
	input wire logic [3:0] menu_index_out,
	input wire logic accept_return_out,
	input wire logic [5:0] display_fault_out,
	input wire logic ready_to_operate_contact_out,
	input wire logic output_stage_enable_out,
	input wire logic brake_engage_out,
	input wire logic [2:0] opmode_out,
	input wire logic service_active_out,
	input wire logic host_ack_out
);
	logic [2:0] up_r;
	logic [2:0] up_nxt;
	logic live;
	logic sel;
	// internal reset copy lags the pin, so judge outputs only once it has let go
	always_comb begin
		up_nxt = (up_r == 3'h7) ? up_r : up_r + 3'h1;
	end
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			up_r <= 3'h0;
		end else begin
			up_r <= up_nxt;
		end
	end
	assign live = up_r > 3'h4;
	assign sel = live && host_valid_in && host_station_in == station_addr_in && station_addr_in < 3'h6;
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!resetn_in);
	sequence s_trip;
		!ready_to_operate_contact_out && !output_stage_enable_out;
	endsequence
	sequence s_accept;
		accept_return_out && menu_index_out == kfs_pkg::MENU_RESET ##1 !accept_return_out;
	endsequence
	property p_uv;
		live && fault_src_in.undervoltage |=> s_trip and display_fault_out == kfs_pkg::FC_UNDERVOLTAGE;
	endproperty
	a_uv: assert property (p_uv) else $error("undervoltage did not trip");
	property p_busoff;
		live && fault_src_in.can_bus_off && brake_installed_in
			|=> brake_engage_out && display_fault_out != kfs_pkg::FC_NONE;
	endproperty
	a_busoff: assert property (p_busoff) else $error("bus-off without brake");
	property p_other;
		live && (fault_src_in.warning_as_fault || fault_src_in.restart_lock_enable && fault_src_in.drive_enable)
			|=> s_trip;
	endproperty
	a_other: assert property (p_other) else $error("fault did not trip");
	property p_warn;
		live && warning_active_in && fault_src_in == '0 && ready_to_operate_contact_out |=> ready_to_operate_contact_out;
	endproperty
	a_warn: assert property (p_warn) else $error("warning opened ready");
	property p_start;
		sel && host_cmd_in.service_start && ready_to_operate_contact_out && fault_src_in == '0
			|=> service_active_out && opmode_out == kfs_pkg::OPMODE_SERVICE && output_stage_enable_out;
	endproperty
	a_start: assert property (p_start) else $error("service start failed");
	property p_off;
		sel && host_cmd_in.host_disable |=> !output_stage_enable_out;
	endproperty
	a_off: assert property (p_off) else $error("disable ignored");
	property p_ack;
		live |=> host_ack_out == $past(sel);
	endproperty
	a_ack: assert property (p_ack) else $error("ack does not match selection");
	property p_accept;
		accept_return_out |-> s_accept;
	endproperty
	a_accept: assert property (p_accept) else $error("accept pulse wrong");
endmodule

// ===== sim/kfs_supervisor_tb.sv
`timescale 1ns/100ps
module kfs_supervisor_tb;
	typedef struct packed {
		logic [3:0] code;
		logic [10:0] kbit;
		logic right;
	} kfs_row_t;
	// out-of-range code is captured as code 0
	localparam kfs_row_t ROWS [12] = '{'{4'hb, 11'ha, 1'b1}, '{4'h0, 11'ha, 1'b0}, '{4'h1, 11'h14, 1'b1},
		'{4'h2, 11'h32, 1'b0}, '{4'h3, 11'h64, 1'b1}, '{4'h4, 11'h7d, 1'b0}, '{4'h5, 11'hfa, 1'b1},
		'{4'h6, 11'h14d, 1'b0}, '{4'h7, 11'h1f4, 1'b1}, '{4'h8, 11'h29a, 1'b0}, '{4'h9, 11'h320, 1'b1},
		'{4'ha, 11'h3e8, 1'b0}};
	localparam logic [5:0] SRC [3] = '{6'h08, 6'h04, 6'h03};
	localparam logic [5:0] CODE [3] = '{kfs_pkg::FC_CAN_BUS_OFF, kfs_pkg::FC_WARNING_AS_FAULT,
		kfs_pkg::FC_RESTART_LOCK_CONFLICT};
	logic clk_in = 1'b0;
	logic resetn_in = 1'b0;
	logic edit_mode_in = 1'b0;
	logic [6:0] node_addr_set_in = 7'h0;
	logic [3:0] baud_code_set_in = 4'h0;
	kfs_pkg::kfs_fault_in_t fault_src_in = '0;
	logic phase_loss_as_warning_in = 1'b0;
	logic brake_installed_in = 1'b1;
	logic warning_active_in = 1'b0;
	logic [5:0] warning_code_in = 6'h5;
	logic reset_request_in = 1'b0;
	logic [2:0] station_addr_in = 3'h3;
	logic acc_seen = 1'b0;
	int bad_count = 0;
	int checked = 0;
	logic key_tick_in, host_valid_in, accept_return_out, extended_menu_out, ready_to_operate_contact_out;
	logic output_stage_enable_out, brake_engage_out, service_active_out, full_restart_out, host_ack_out;
	logic [3:0] keys, menu_index_out;
	logic [2:0] host_station_in, opmode_out;
	logic [15:0] edit_value_out;
	logic [6:0] node_addr_out;
	logic [10:0] baud_kbit_out;
	logic [5:0] display_fault_out, display_warning_out;
	kfs_pkg::kfs_host_cmd_t host_cmd_in;
	kfs_panel_model panel_u (.clk_in, .key_tick_out(key_tick_in), .keys_out(keys), .host_valid_out(host_valid_in),
		.host_station_out(host_station_in), .host_cmd_out(host_cmd_in));
	kfs_supervisor #(.GAP_TICKS(16'h4)) dut_u (.*, .key_up_in(keys[3]), .key_down_in(keys[2]),
		.key_left_in(keys[1]), .key_right_in(keys[0]));
	initial forever #50 clk_in = ~clk_in;
	always @(posedge clk_in) if (accept_return_out === 1'b1) acc_seen <= 1'b1;
	task automatic ck(input string what, input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic w(input int n);
		repeat (n) @(negedge clk_in);
	endtask
	// supply off and on: the only way new node settings land
	task automatic power_cycle();
		resetn_in = 1'b0;
		w(4);
		resetn_in = 1'b1;
		w(5);
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		w(1);
		for (int i = 0; i < 12; i++) begin
			node_addr_set_in = 7'(i + 32);
			baud_code_set_in = ROWS[i].code;
			panel_u.hold({3'h0, ROWS[i].right});
			power_cycle();
			panel_u.hold(4'h0);
			ck("baud", ROWS[i].kbit, baud_kbit_out);
			ck("ext", ROWS[i].right, extended_menu_out);
			ck("node", 16'(i + 32), node_addr_out);
		end
		baud_code_set_in = 4'h1;
		w(3);
		ck("baud_kept", 16'h3e8, baud_kbit_out);
		$display("power-up table done");
		edit_mode_in = 1'b1;
		panel_u.press(4'h8, 4'h0, 4);
		ck("up1", kfs_pkg::EDIT_STEP_ONE, edit_value_out);
		panel_u.press(4'h8, 4'h0, 1);
		panel_u.press(4'h8, 4'h0, 4);
		ck("up10", 16'hb, edit_value_out);
		panel_u.press(4'h4, 4'h0, 1);
		panel_u.press(4'h4, 4'h0, 4);
		ck("dn10", 16'h1, edit_value_out);
		panel_u.press(4'h4, 4'h0, 4);
		ck("dn1", kfs_pkg::EDIT_RESET, edit_value_out);
		edit_mode_in = 1'b0;
		panel_u.press(4'h8, 4'h0, 4);
		panel_u.press(4'h8, 4'h0, 4);
		panel_u.press(4'h4, 4'h0, 4);
		ck("menu", 16'h1, menu_index_out);
		panel_u.press(4'h1, 4'h1, 1);
		panel_u.press(4'h3, 4'h0, 4);
		ck("chord", 16'h10, {11'h0, acc_seen, menu_index_out});
		$display("keys done");
		warning_active_in = 1'b1;
		phase_loss_as_warning_in = 1'b1;
		w(1);
		fault_src_in.phase_loss = 1'b1;
		w(2);
		ck("warn", 16'h45, {ready_to_operate_contact_out, display_warning_out});
		ck("masked", kfs_pkg::FC_NONE, display_fault_out);
		phase_loss_as_warning_in = 1'b0;
		warning_active_in = 1'b0;
		w(2);
		fault_src_in = '0;
		ck("phase", kfs_pkg::FC_PHASE_LOSS, display_fault_out);
		panel_u.send(3'h3, 4'h1);
		w(1);
		ck("clear", kfs_pkg::FC_NONE, display_fault_out);
		fault_src_in.undervoltage = 1'b1;
		w(1);
		fault_src_in = '0;
		w(1);
		ck("uv", {7'h1, kfs_pkg::FC_UNDERVOLTAGE}, {ready_to_operate_contact_out, output_stage_enable_out,
			brake_engage_out, display_fault_out});
		reset_request_in = 1'b1;
		w(1);
		reset_request_in = 1'b0;
		ck("uv_rst", 16'h0, full_restart_out);
		w(1);
		ck("uv_clr", kfs_pkg::FC_NONE, display_fault_out);
		$display("clearable faults done");
		panel_u.send(3'h2, 4'h8);
		ck("other", 16'h0, host_ack_out);
		station_addr_in = 3'h6;
		panel_u.send(3'h6, 4'h8);
		ck("six", 16'h0, host_ack_out);
		station_addr_in = 3'h3;
		panel_u.send(3'h3, 4'h8);
		ck("ack", 16'h1, host_ack_out);
		w(1);
		ck("start", {13'h3, kfs_pkg::OPMODE_SERVICE}, {service_active_out, output_stage_enable_out, opmode_out});
		panel_u.send(3'h3, 4'h4);
		w(1);
		ck("stop", 16'h1, {service_active_out, output_stage_enable_out});
		panel_u.send(3'h3, 4'h2);
		w(1);
		ck("off", 16'h0, output_stage_enable_out);
		$display("service done");
		for (int i = 0; i < 3; i++) begin
			brake_installed_in = 1'(i != 1);
			panel_u.send(3'h3, 4'h8);
			fault_src_in = SRC[i];
			w(1);
			fault_src_in = '0;
			w(1);
			ck("code", CODE[i], display_fault_out);
			ck("trip", {2'b00, brake_installed_in}, {ready_to_operate_contact_out, output_stage_enable_out,
				brake_engage_out});
			reset_request_in = 1'b1;
			w(1);
			ck("restart", 16'h1, full_restart_out);
			reset_request_in = 1'b0;
			ck("kept", CODE[i], display_fault_out);
			power_cycle();
		end
		$display("latched faults done");
		print_verdict();
	end
endmodule
bind kfs_supervisor kfs_supervisor_asserts chk_u (.*);
